/* pixel_formatter_pkg.sv */
// Purpose: shared constants and types of the pixel formatter
// Assumes: one core clock, synchronous active-high reset
// Notes: offsets are byte addresses on the register bus
// Behaviour
// RULE_01: ten bits per channel in and out
// RULE_02: lines up to 4096 pixels wide
// RULE_03: dimension register stores size minus one
// RULE_04: software programs even width and height
// RULE_05: chroma exchange bit swaps blue and red
// RULE_06: depth bit zero eight, one ten
// RULE_07: depth cut applies to all channels
// RULE_08: layout field picks 444, 422, 420
// RULE_09: packing type picks channel arrangement zero/one
// RULE_10: 444 mode only rearranges channels
// RULE_11: 422 mode halves chroma horizontally, rearranges
// RULE_12: 420 mode halves chroma both ways, rearranges
// RULE_13: three-bit horizontal filter pick per chroma
// RULE_14: two-bit vertical filter pick per chroma
// RULE_15: enable bit clear stops formatter work
// RULE_16: control bit 31 turns self test on
// RULE_17: register writes take effect at once
// RULE_18: capability reports line limit code one
// RULE_19: software reaches registers over register bus
// RULE_20: capability bit zero reports 420 support
// RULE_21: eight-bit output drops two low bits
// RULE_22: streams carry valid, frame and line markers
package pixel_formatter_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_DIMENSION = 8'h04;
  localparam logic [7:0] OFF_EXCHANGE = 8'h08;
  localparam logic [7:0] OFF_DEPTH = 8'h0c;
  localparam logic [7:0] OFF_LAYOUT = 8'h10;
  localparam logic [7:0] OFF_FILTER = 8'h14;
  localparam logic [7:0] OFF_CAPABILITY = 8'h18;

  // reset values
  localparam logic [31:0] RST_CONTROL = 32'h0000_0000;
  localparam logic [31:0] RST_DIMENSION = 32'h0000_0000;
  localparam logic [31:0] RST_EXCHANGE = 32'h0000_0000;
  localparam logic [31:0] RST_DEPTH = 32'h0000_0000;
  localparam logic [31:0] RST_LAYOUT = 32'h0000_0000;
  localparam logic [31:0] RST_FILTER = 32'h0000_0000;
  localparam logic [31:0] CAPABILITY_VALUE = 32'h0000_0005;

  // writable bits of each register, reserved bits read zero
  localparam logic [31:0] MASK_CONTROL = 32'h8000_0001;
  localparam logic [31:0] MASK_DIMENSION = 32'h1fff_1fff;
  localparam logic [31:0] MASK_EXCHANGE = 32'h0000_0001;
  localparam logic [31:0] MASK_DEPTH = 32'h0000_0001;
  localparam logic [31:0] MASK_LAYOUT = 32'h0003_0003;
  localparam logic [31:0] MASK_FILTER = 32'h0307_0307;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_ENABLE_POS = 0;
  localparam int CTRL_SELF_TEST_POS = 31;
  localparam int DIM_WIDTH_LSB = 0;
  localparam int DIM_HEIGHT_LSB = 16;
  localparam int DIM_BITS = 13;
  localparam int EXCHANGE_POS = 0;
  localparam int DEPTH_POS = 0;
  localparam int LAYOUT_LSB = 0;
  localparam int PACKING_LSB = 16;
  localparam int CHAN0_HORIZ_LSB = 0;
  localparam int CHAN0_VERT_LSB = 8;
  localparam int CHAN1_HORIZ_LSB = 16;
  localparam int CHAN1_VERT_LSB = 24;

  // stream geometry
  localparam int COMP_BITS = 10;
  localparam int MAX_LINE_PIXELS = 4096;

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    LAYOUT_444 = 2'b00,
    LAYOUT_422 = 2'b01,
    LAYOUT_420 = 2'b10,
    LAYOUT_RSVD = 2'b11
  } layout_e;

  typedef enum logic [1:0] {
    VERT_TOP = 2'b00,
    VERT_AVERAGE = 2'b01,
    VERT_BOTTOM = 2'b10,
    VERT_RSVD = 2'b11
  } vert_pick_e;

endpackage

/* chroma_horiz_decimate.sv */
// Purpose: horizontal chroma halving over pixel pairs
// Assumes: pixels arrive in pairs, even pixel first
// Notes: one cycle latency for every pixel, chroma valid on odd pixels when halving
`timescale 1ns/1ps
module chroma_horiz_decimate #(
  parameter int COMP_BITS = 10
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic decimate,
  input wire logic [1:0][2:0] horiz_pick,
  input wire logic in_valid,
  input wire logic in_sof,
  input wire logic in_eol,
  input wire logic in_odd,
  input wire logic [COMP_BITS-1:0] in_luma,
  input wire logic [1:0][COMP_BITS-1:0] in_chroma,
  output logic out_valid,
  output logic out_sof,
  output logic out_eol,
  output logic out_chroma_valid,
  output logic [COMP_BITS-1:0] out_luma,
  output logic [1:0][COMP_BITS-1:0] out_chroma
);

  if (COMP_BITS < 2) begin : g_bad_bits
    $error("COMP_BITS too small");
  end

  // weight of the left sample in eighths for each filter type
  function automatic logic [3:0] left_weight(input logic [2:0] pick);
    case (pick)
      3'd0: left_weight = 4'd8;
      3'd1: left_weight = 4'd4;
      3'd2: left_weight = 4'd0;
      3'd3: left_weight = 4'd6;
      3'd4: left_weight = 4'd2;
      3'd5: left_weight = 4'd7;
      3'd6: left_weight = 4'd5;
      default: left_weight = 4'd3;
    endcase
  endfunction

  // stream markers and luma pass through one register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      out_sof <= 1'b0;
      out_eol <= 1'b0;
      out_chroma_valid <= 1'b0;
      out_luma <= '0;
    end else begin
      out_valid <= in_valid;
      out_sof <= in_sof;
      out_eol <= in_eol;
      out_chroma_valid <= in_valid & (~decimate | in_odd); // RULE_11
      out_luma <= in_luma;
    end
  end

  // per chroma channel: hold even sample, blend on odd one
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [COMP_BITS-1:0] left_r;
    logic [3:0] w;
    logic [COMP_BITS+4:0] blend;
    assign w = left_weight(horiz_pick[ch]); // RULE_13
    assign blend = (COMP_BITS+5)'(left_r) * w
                 + (COMP_BITS+5)'(in_chroma[ch]) * (4'd8 - w)
                 + (COMP_BITS+5)'(4);
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        left_r <= '0;
      end else if (in_valid & ~in_odd) begin
        left_r <= in_chroma[ch];
      end
    end
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        out_chroma[ch] <= '0;
      end else if (in_valid) begin
        out_chroma[ch] <= decimate ? blend[COMP_BITS+2:3] : in_chroma[ch]; // RULE_10
      end
    end
  end

endmodule

/* chroma_vert_decimate.sv */
// Purpose: vertical chroma halving with one line of chroma pairs
// Assumes: lines arrive in pairs, even line first, equal width
// Notes: one cycle latency; even lines carry no chroma when halving
`timescale 1ns/1ps
module chroma_vert_decimate #(
  parameter int COMP_BITS = 10,
  parameter int MAX_PAIRS = 2048
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic decimate,
  input wire logic [1:0][1:0] vert_pick,
  input wire logic in_valid,
  input wire logic in_sof,
  input wire logic in_eol,
  input wire logic in_chroma_valid,
  input wire logic in_odd_line,
  input wire logic [$clog2(MAX_PAIRS)-1:0] in_pair,
  input wire logic [COMP_BITS-1:0] in_luma,
  input wire logic [1:0][COMP_BITS-1:0] in_chroma,
  output logic out_valid,
  output logic out_sof,
  output logic out_eol,
  output logic out_chroma_valid,
  output logic [COMP_BITS-1:0] out_luma,
  output logic [1:0][COMP_BITS-1:0] out_chroma
);

  if (MAX_PAIRS < 2) begin : g_bad_pairs
    $error("MAX_PAIRS too small");
  end

  // chroma of the upper line of each pair
  logic [1:0][COMP_BITS-1:0] line_mem [MAX_PAIRS];
  logic store;
  assign store = decimate & in_valid & in_chroma_valid & ~in_odd_line;

  // upper line written, lower line reads it back
  always_ff @(posedge clock) begin
    if (store) begin
      line_mem[in_pair] <= in_chroma; // RULE_02
    end
  end

  // markers and luma through one register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      out_sof <= 1'b0;
      out_eol <= 1'b0;
      out_chroma_valid <= 1'b0;
      out_luma <= '0;
    end else begin
      out_valid <= in_valid;
      out_sof <= in_sof;
      out_eol <= in_eol;
      out_chroma_valid <= in_valid & in_chroma_valid & (~decimate | in_odd_line); // RULE_12
      out_luma <= in_luma;
    end
  end

  // per chroma channel vertical blend
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [COMP_BITS-1:0] top;
    logic [COMP_BITS:0] sum;
    logic [COMP_BITS-1:0] pick_val;
    assign top = line_mem[in_pair][ch];
    assign sum = (COMP_BITS+1)'(top) + (COMP_BITS+1)'(in_chroma[ch]) + (COMP_BITS+1)'(1);
    always_comb begin
      case (vert_pick[ch]) // RULE_14
        2'b01: pick_val = sum[COMP_BITS:1];
        2'b10: pick_val = in_chroma[ch];
        default: pick_val = top;
      endcase
    end
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        out_chroma[ch] <= '0;
      end else if (in_valid) begin
        out_chroma[ch] <= decimate ? pick_val : in_chroma[ch];
      end
    end
  end

endmodule

/* yuv_pixel_formatter.sv */
// Purpose: chroma swap, subsampling, packing and depth cut of pixels
// Assumes: AHB-Lite slave in a zero-wait-state fabric
// Notes: stream has no back-pressure; pixels move one per valid cycle
`timescale 1ns/1ps
module yuv_pixel_formatter #(
  parameter int MAX_LINE_PIXELS = pixel_formatter_pkg::MAX_LINE_PIXELS
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic in_valid,
  input wire logic in_frame_start,
  input wire logic in_line_end,
  input wire logic [9:0] in_luma,
  input wire logic [9:0] in_cb,
  input wire logic [9:0] in_cr,
  output logic out_valid,
  output logic out_frame_start,
  output logic out_line_end,
  output logic out_chroma_valid,
  output logic [9:0] out_luma,
  output logic [9:0] out_chan0,
  output logic [9:0] out_chan1
);

  localparam int CB = pixel_formatter_pkg::COMP_BITS;
  localparam int DB = pixel_formatter_pkg::DIM_BITS;
  localparam int PAIRS = MAX_LINE_PIXELS / 2;
  localparam int PB = $clog2(PAIRS);

  if (MAX_LINE_PIXELS != 2048 && MAX_LINE_PIXELS != 4096) begin : g_bad_width
    $error("MAX_LINE_PIXELS must be 2048 or 4096");
  end

  // ---------------------------------------------------------------
  // register bus slave
  // ---------------------------------------------------------------
  logic [31:0] control_r;
  logic [31:0] dimension_r;
  logic [31:0] exchange_r;
  logic [31:0] depth_r;
  logic [31:0] layout_r;
  logic [31:0] filter_r;
  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] addr_r;
  logic [3:0] byte_en_r;
  logic [3:0] byte_en;
  logic [31:0] lane_mask;
  logic take;

  // zero wait state, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign take = hsel & hready & htrans[1];

  // byte enables from size and low address bits
  always_comb begin
    case (hsize)
      3'b000: byte_en = 4'b0001 << haddr[1:0];
      3'b001: byte_en = haddr[1] ? 4'b1100 : 4'b0011;
      default: byte_en = 4'b1111;
    endcase
  end

  // address phase capture
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
      byte_en_r <= 4'b0000;
    end else if (hready) begin
      wr_pend_r <= take & hwrite;
      rd_pend_r <= take & ~hwrite;
      addr_r <= {haddr[7:2], 2'b00};
      byte_en_r <= byte_en;
    end
  end

  // expand byte enables to a bit mask
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign lane_mask[8*b+7:8*b] = {8{byte_en_r[b]}};
  end

  // data phase writes land at once, no shadow copy
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      control_r <= pixel_formatter_pkg::RST_CONTROL;
      dimension_r <= pixel_formatter_pkg::RST_DIMENSION;
      exchange_r <= pixel_formatter_pkg::RST_EXCHANGE;
      depth_r <= pixel_formatter_pkg::RST_DEPTH;
      layout_r <= pixel_formatter_pkg::RST_LAYOUT;
      filter_r <= pixel_formatter_pkg::RST_FILTER;
    end else if (wr_pend_r) begin // RULE_17
      case (addr_r)
        pixel_formatter_pkg::OFF_CONTROL:
          control_r <= (control_r & ~lane_mask)
                     | (hwdata & lane_mask & pixel_formatter_pkg::MASK_CONTROL);
        pixel_formatter_pkg::OFF_DIMENSION:
          dimension_r <= (dimension_r & ~lane_mask)
                       | (hwdata & lane_mask & pixel_formatter_pkg::MASK_DIMENSION);
        pixel_formatter_pkg::OFF_EXCHANGE:
          exchange_r <= (exchange_r & ~lane_mask)
                      | (hwdata & lane_mask & pixel_formatter_pkg::MASK_EXCHANGE);
        pixel_formatter_pkg::OFF_DEPTH:
          depth_r <= (depth_r & ~lane_mask)
                   | (hwdata & lane_mask & pixel_formatter_pkg::MASK_DEPTH);
        pixel_formatter_pkg::OFF_LAYOUT:
          layout_r <= (layout_r & ~lane_mask)
                    | (hwdata & lane_mask & pixel_formatter_pkg::MASK_LAYOUT);
        pixel_formatter_pkg::OFF_FILTER:
          filter_r <= (filter_r & ~lane_mask)
                    | (hwdata & lane_mask & pixel_formatter_pkg::MASK_FILTER);
        default: begin
        end
      endcase
    end
  end

  // read mux on the captured address, unmapped reads zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (rd_pend_r) begin
      case (addr_r)
        pixel_formatter_pkg::OFF_CONTROL: hrdata = control_r;
        pixel_formatter_pkg::OFF_DIMENSION: hrdata = dimension_r;
        pixel_formatter_pkg::OFF_EXCHANGE: hrdata = exchange_r;
        pixel_formatter_pkg::OFF_DEPTH: hrdata = depth_r;
        pixel_formatter_pkg::OFF_LAYOUT: hrdata = layout_r;
        pixel_formatter_pkg::OFF_FILTER: hrdata = filter_r;
        pixel_formatter_pkg::OFF_CAPABILITY: // RULE_18 RULE_20
          hrdata = pixel_formatter_pkg::CAPABILITY_VALUE
                 ^ {29'h0000_0000, MAX_LINE_PIXELS == 2048, 2'h0}; // code 0 for 2048
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // decoded configuration
  // ---------------------------------------------------------------
  logic enable, self_test, exchange, depth_full, packing_alt, halve_h, halve_v;
  logic [DB-1:0] width_m1, height_m1;
  logic [1:0] layout;
  logic [1:0][2:0] horiz_pick;
  logic [1:0][1:0] vert_pick;

  assign enable = control_r[pixel_formatter_pkg::CTRL_ENABLE_POS];
  assign self_test = control_r[pixel_formatter_pkg::CTRL_SELF_TEST_POS];
  assign width_m1 = dimension_r[pixel_formatter_pkg::DIM_WIDTH_LSB +: DB]; // RULE_03
  assign height_m1 = dimension_r[pixel_formatter_pkg::DIM_HEIGHT_LSB +: DB]; // RULE_03
  assign exchange = exchange_r[pixel_formatter_pkg::EXCHANGE_POS];
  assign depth_full = depth_r[pixel_formatter_pkg::DEPTH_POS];
  assign layout = layout_r[pixel_formatter_pkg::LAYOUT_LSB +: 2];
  // reserved packing codes behave as type zero
  assign packing_alt = (layout_r[pixel_formatter_pkg::PACKING_LSB +: 2] == 2'b01); // RULE_09
  // reserved layout behaves as 444
  assign halve_h = (layout == pixel_formatter_pkg::LAYOUT_422)
                 | (layout == pixel_formatter_pkg::LAYOUT_420); // RULE_08
  assign halve_v = (layout == pixel_formatter_pkg::LAYOUT_420); // RULE_08
  assign horiz_pick[0] = filter_r[pixel_formatter_pkg::CHAN0_HORIZ_LSB +: 3];
  assign horiz_pick[1] = filter_r[pixel_formatter_pkg::CHAN1_HORIZ_LSB +: 3];
  assign vert_pick[0] = filter_r[pixel_formatter_pkg::CHAN0_VERT_LSB +: 2];
  assign vert_pick[1] = filter_r[pixel_formatter_pkg::CHAN1_VERT_LSB +: 2];

  // ---------------------------------------------------------------
  // source select and position counters
  // ---------------------------------------------------------------
  logic [DB-1:0] col_r, row_r, col_now, row_now;
  logic src_valid, src_sof, src_eol_in, line_done;
  logic [CB-1:0] src_luma, src_cb, src_cr;

  // pattern source replaces upstream while self test is on
  always_comb begin
    if (self_test) begin // RULE_16
      src_valid = enable;
      src_sof = (col_r == '0) & (row_r == '0);
      src_eol_in = 1'b0;
      src_luma = col_r[CB-1:0];
      src_cb = row_r[CB-1:0];
      src_cr = ~col_r[CB-1:0];
    end else begin
      src_valid = enable & in_valid; // RULE_15
      src_sof = in_frame_start;
      src_eol_in = in_line_end;
      src_luma = in_luma;
      src_cb = in_cb;
      src_cr = in_cr;
    end
  end

  // a frame start resets the position to the origin
  assign col_now = src_sof ? '0 : col_r;
  assign row_now = src_sof ? '0 : row_r;
  assign line_done = (col_now == width_m1) | src_eol_in;

  // counters advance only on a pixel, frozen while disabled
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      col_r <= '0;
      row_r <= '0;
    end else if (src_valid) begin
      if (line_done) begin
        col_r <= '0;
        row_r <= (row_now == height_m1) ? '0 : row_now + 1'b1;
      end else begin
        col_r <= col_now + 1'b1;
        row_r <= row_now;
      end
    end
  end

  // ---------------------------------------------------------------
  // stage one: exchange of chroma
  // ---------------------------------------------------------------
  logic s1_valid_r;
  logic s1_sof_r;
  logic s1_eol_r;
  logic s1_odd_px_r;
  logic s1_odd_line_r;
  logic [PB-1:0] s1_pair_r;
  logic [CB-1:0] s1_luma_r;
  logic [1:0][CB-1:0] s1_chroma_r;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s1_valid_r <= 1'b0;
      s1_sof_r <= 1'b0;
      s1_eol_r <= 1'b0;
      s1_odd_px_r <= 1'b0;
      s1_odd_line_r <= 1'b0;
      s1_pair_r <= '0;
      s1_luma_r <= '0;
      s1_chroma_r <= '0;
    end else begin
      s1_valid_r <= src_valid; // RULE_22
      s1_sof_r <= src_valid & src_sof;
      s1_eol_r <= src_valid & line_done;
      if (src_valid) begin
        s1_odd_px_r <= col_now[0];
        s1_odd_line_r <= row_now[0];
        s1_pair_r <= col_now[PB:1];
        s1_luma_r <= src_luma;
        s1_chroma_r[0] <= exchange ? src_cr : src_cb; // RULE_05
        s1_chroma_r[1] <= exchange ? src_cb : src_cr; // RULE_05
      end
    end
  end

  // position follows the horizontal stage by one cycle
  logic s2_odd_line_r;
  logic [PB-1:0] s2_pair_r;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s2_odd_line_r <= 1'b0;
      s2_pair_r <= '0;
    end else if (s1_valid_r) begin
      s2_odd_line_r <= s1_odd_line_r;
      s2_pair_r <= s1_pair_r;
    end
  end

  // ---------------------------------------------------------------
  // stages two and three: chroma halving
  // ---------------------------------------------------------------
  logic h_valid, h_sof, h_eol, h_cvalid;
  logic [CB-1:0] h_luma;
  logic [1:0][CB-1:0] h_chroma;
  logic v_valid, v_sof, v_eol, v_cvalid;
  logic [CB-1:0] v_luma;
  logic [1:0][CB-1:0] v_chroma;

  chroma_horiz_decimate #(
    .COMP_BITS(CB)
  ) u_horiz (
    .clock(clock),
    .sys_rst(sys_rst),
    .decimate(halve_h), // RULE_11
    .horiz_pick(horiz_pick), // RULE_13
    .in_valid(s1_valid_r),
    .in_sof(s1_sof_r),
    .in_eol(s1_eol_r),
    .in_odd(s1_odd_px_r),
    .in_luma(s1_luma_r),
    .in_chroma(s1_chroma_r),
    .out_valid(h_valid),
    .out_sof(h_sof),
    .out_eol(h_eol),
    .out_chroma_valid(h_cvalid),
    .out_luma(h_luma),
    .out_chroma(h_chroma)
  );

  chroma_vert_decimate #(
    .COMP_BITS(CB),
    .MAX_PAIRS(PAIRS)
  ) u_vert (
    .clock(clock),
    .sys_rst(sys_rst),
    .decimate(halve_v), // RULE_12
    .vert_pick(vert_pick), // RULE_14
    .in_valid(h_valid),
    .in_sof(h_sof),
    .in_eol(h_eol),
    .in_chroma_valid(h_cvalid),
    .in_odd_line(s2_odd_line_r),
    .in_pair(s2_pair_r),
    .in_luma(h_luma),
    .in_chroma(h_chroma),
    .out_valid(v_valid),
    .out_sof(v_sof),
    .out_eol(v_eol),
    .out_chroma_valid(v_cvalid),
    .out_luma(v_luma),
    .out_chroma(v_chroma)
  );

  // ---------------------------------------------------------------
  // stage four: packing and depth reduction
  // ---------------------------------------------------------------
  function automatic logic [CB-1:0] cut_depth(input logic [CB-1:0] v, input logic full);
    cut_depth = full ? v : {2'b00, v[CB-1:2]}; // RULE_06 RULE_21
  endfunction

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      out_frame_start <= 1'b0;
      out_line_end <= 1'b0;
      out_chroma_valid <= 1'b0;
      out_luma <= '0;
      out_chan0 <= '0;
      out_chan1 <= '0;
    end else begin
      out_valid <= v_valid; // RULE_22
      out_frame_start <= v_sof;
      out_line_end <= v_eol;
      out_chroma_valid <= v_cvalid;
      if (v_valid) begin
        // same cut on every channel
        out_luma <= cut_depth(v_luma, depth_full); // RULE_07 RULE_01
        out_chan0 <= cut_depth(v_chroma[packing_alt ? 1 : 0], depth_full); // RULE_09 RULE_07
        out_chan1 <= cut_depth(v_chroma[packing_alt ? 0 : 1], depth_full); // RULE_10 RULE_07
      end
    end
  end

endmodule

/* pf_props.sv */
// Purpose: bus and stream checks of the pixel formatter
// Assumes: sees the top module ports only
// Notes: bound to every formatter instance below
`timescale 1ns/1ps
module pf_props (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic in_valid,
  input wire logic in_frame_start,
  input wire logic out_valid,
  input wire logic out_frame_start,
  input wire logic out_line_end,
  input wire logic out_chroma_valid
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // read taken in its address phase
  sequence rd_req;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  a_ready_high:
    assert property (hreadyout) else $error("bus ready low");
  a_caps_value:
    assert property (rd_req ##0 haddr[7:0] == 8'h18 |=> hrdata == 32'h0000_0005)
    else $error("capability read wrong");
  a_unmapped_zero:
    assert property (rd_req ##0 haddr[7:0] > 8'h1b |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_idle_rdata:
    assert property (!(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0000_0000)
    else $error("read data without read");
  a_pixel_delay:
    assert property (out_valid |-> $past(in_valid, 4)) else $error("pixel out of step");
  a_sof_delay:
    assert property (out_frame_start |-> out_valid && $past(in_frame_start, 4))
    else $error("frame start out of step");
  a_chroma_qual:
    assert property (out_chroma_valid |-> out_valid) else $error("chroma without pixel");
  a_eol_qual:
    assert property (out_line_end |-> out_valid) else $error("line end without pixel");
endmodule
bind yuv_pixel_formatter pf_props u_props (.*);

/* pixel_source.sv */
// Purpose: upstream stage feeding whole frames
// Assumes: 8 by 4 frames, both sizes even
// Notes: data lines invert once a frame ends
`timescale 1ns/1ps
module pixel_source (
  input wire logic clock,
  output logic in_valid,
  output logic in_frame_start,
  output logic in_line_end,
  output logic [9:0] in_luma,
  output logic [9:0] in_cb,
  output logic [9:0] in_cr
);
  initial begin
    in_valid = 0;
    in_frame_start = 0;
    in_line_end = 0;
    in_luma = 10'h155;
    in_cb = 10'h2aa;
    in_cr = 10'h155;
  end
  // one pixel a cycle, markers on first and last pixels
  task automatic send_frame();
    for (int y = 0; y < 4; y++)
      for (int x = 0; x < 8; x++) begin
        @(negedge clock);
        in_valid = 1;
        in_frame_start = x == 0 && y == 0;
        in_line_end = x == 7;
        in_luma = 10'(200 + 32 * x + y);
        in_cb = 10'(64 + 16 * x + 8 * y);
        in_cr = 10'(900 - 12 * x - 4 * y);
      end
    @(negedge clock);
    in_valid = 0;
    in_frame_start = 0;
    in_line_end = 0;
    in_luma = ~in_luma;
    in_cb = ~in_cb;
    in_cr = ~in_cr;
  endtask
endmodule

/* testbench.sv */
// Purpose: register and pixel tests of the pixel formatter
// Assumes: source model sends 8 by 4 frames
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
module testbench;
  logic clock = 0, sys_rst = 1, hsel = 0, hwrite = 0, hready = 1;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'b010;
  logic hreadyout, hresp, in_valid, in_frame_start, in_line_end;
  logic out_valid, out_frame_start, out_line_end, out_chroma_valid;
  logic [9:0] in_luma, in_cb, in_cr, out_luma, out_chan0, out_chan1;
  int bad_count = 0, checks = 0, lay, xch, dep, pk, hp, vp, n;
  int wt[8] = '{8, 4, 0, 6, 2, 7, 5, 3};
  logic [31:0] msk[7] = '{32'h8000_0001, 32'h1fff_1fff, 32'h0000_0001, 32'h0000_0001,
    32'h0003_0003, 32'h0307_0307, 32'h0000_0005};
  always #5 clock = ~clock;
  yuv_pixel_formatter DUT (.*);
  pixel_source src (.*);
  function automatic int chv(int c, int x, int y);
    return c ? 900 - 12 * x - 4 * y : 64 + 16 * x + 8 * y;
  endfunction
  function automatic int hf(int c, int x, int y);
    if (lay == 0) return chv(c, x, y);
    return (chv(c, x - 1, y) * wt[hp] + chv(c, x, y) * (8 - wt[hp]) + 4) >> 3;
  endfunction
  function automatic int vf(int c, int x, int y);
    if (lay != 2 || vp == 2) return hf(c, x, y);
    if (vp == 0) return hf(c, x, y - 1);
    return (hf(c, x, y - 1) + hf(c, x, y) + 1) >> 1;
  endfunction
  function automatic int sc(int v);
    return dep ? v : v >> 2;
  endfunction
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s exp %h saw %h", nm, e, s);
    end
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // address phase, then release for the data phase
  task automatic req(logic [31:0] a, logic w);
    haddr = a;
    hwrite = w;
    hsel = 1;
    htrans = 2'b10;
    @(negedge clock);
    hsel = 0;
    htrans = 2'b00;
  endtask
  task automatic wr(logic [31:0] a, logic [31:0] d);
    req(a, 1);
    hwdata = d;
    @(negedge clock);
  endtask
  task automatic rd(logic [31:0] a, logic [31:0] e);
    req(a, 0);
    chk("hrdata", hrdata, e);
    chk("hresp", hresp, 0);
    @(negedge clock);
  endtask
  // one frame in, every output pixel compared
  task automatic frame();
    int x, y, cv, f, s;
    n = 0;
    fork
      src.send_frame();
      for (int t = 0; t < 200 && n < 32; t++) begin
        @(negedge clock);
        if (out_valid === 1'b1) begin
          x = n % 8;
          y = n / 8;
          cv = lay == 0 || (x % 2 == 1 && (lay == 1 || y % 2 == 1));
          f = vf(xch, x, y);
          s = vf(1 - xch, x, y);
          chk("luma", out_luma, sc(200 + 32 * x + y));
          chk("sof", out_frame_start, n == 0);
          chk("eol", out_line_end, x == 7);
          chk("cvalid", out_chroma_valid, cv);
          if (cv) chk("chan0", out_chan0, sc(pk ? s : f));
          if (cv) chk("chan1", out_chan1, sc(pk ? f : s));
          n++;
        end
      end
    join
    if (n < 32) begin
      bad_count++;
      end_of_test();
    end
  endtask
  initial begin
    repeat (5) @(negedge clock);
    sys_rst = 0;
    for (int k = 0; k < 7; k++) rd(4 * k, k == 6 ? 32'h0000_0005 : 0);
    for (int k = 1; k < 7; k++) begin
      wr(4 * k, 32'hffff_ffff);
      rd(4 * k, msk[k]);
    end
    rd(8'h1c, 0);
    wr(8'h00, 32'h8000_0000);
    rd(8'h00, 32'h8000_0000);
    wr(8'h04, 32'h0003_0007);
    wr(8'h00, 32'h0000_0001);
    for (int i = 0; i < 12; i++) begin
      lay = i == 0 ? 0 : (i < 9 ? 1 : 2);
      xch = i == 0 || i == 10;
      dep = i != 0 && i != 10;
      pk = i % 2;
      hp = i % 8;
      vp = i % 3;
      wr(8'h08, xch);
      wr(8'h0c, dep);
      wr(8'h10, lay | pk << 16);
      wr(8'h14, (hp | vp << 8) * 32'h0001_0001);
      frame();
    end
    wr(8'h00, 32'h0000_0000);
    n = 0;
    fork
      src.send_frame();
      repeat (50) begin
        @(negedge clock);
        if (out_valid !== 1'b0) n++;
      end
    join
    chk("dropped", n, 0);
    end_of_test();
  end
endmodule
